//--- wds_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef WDS_REGS_SVH
`define WDS_REGS_SVH
`define WDS_AUX_OFFSET 8'hA2
`define WDS_FEED_OFFSET 8'hA6
`define WDS_CTRL_OFFSET 8'hA7
`define WDS_STATUS_OFFSET 8'hA8
`define WDS_MASK_OFFSET 8'hA9
`define WDS_COUNT_OFFSET 8'hAA
`define WDS_AUX_RESET 8'h00
`define WDS_AUX_SOFTWARE_RESET_BIT_BIT 3
`define WDS_AUX_RSVD_BIT 1
`define WDS_AUX_PBS_BIT 0
`define WDS_CTRL_SEL_RESET 3'h7
`define WDS_CTRL_RUN_BIT 4
`define WDS_CTRL_LOCK_BIT 5
`define WDS_CTRL_FUSE_BIT 6
`define WDS_ST_INTERVAL_BIT 0
`define WDS_ST_BADFEED_BIT 1
`define WDS_ST_WDRESET_BIT 2
`define WDS_ST_RESET 3'h0
`define WDS_MASK_RESET 3'h0
`define WDS_FEED_FIRST 8'h1E
`define WDS_FEED_SECOND 8'hE1
`define WDS_CLK_MHZ 40
`define WDS_BASE_PERIOD_US 16000
`define WDS_BASE_CYCLES (`WDS_BASE_PERIOD_US * `WDS_CLK_MHZ)
`define WDS_RST_PULSE_NS 1000
`define WDS_RST_PULSE_CYCLES ((`WDS_RST_PULSE_NS * `WDS_CLK_MHZ) / 1000)
`define WDS_PRE_W 20
`define WDS_PULSE_W 8
`define WDS_PERIOD_W 8
`endif

//--- wds_pkg.sv
// Types shared by the watchdog and soft reset block
package wds_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wds_bus_req_type;

    typedef enum logic [1:0] {
        WDS_RST_IDLE,
        WDS_RST_PULSE,
        WDS_RST_OSC_WAIT
    } wds_rst_state_type;
endpackage

//--- wds_counter.sv
// Wrapping cycle counter with clear, run and terminal pulse
`timescale 1ns/1ps
module wds_counter #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic clear,
    input wire logic run,
    input wire logic [W-1:0] limit,
    // Terminal count
    output logic done
);
    logic [W-1:0] count;
    wire at_limit = (count == limit);
    wire [W-1:0] count_inc = count + {{(W-1){1'b0}}, 1'b1};
    wire [W-1:0] next_count = clear ? '0 :
                              !run ? count :
                              at_limit ? '0 : count_inc;

    assign done = run && !clear && at_limit;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule

//--- wds_feed_seq.sv
// Two-write feed sequence detector
`timescale 1ns/1ps
`include "wds_regs.svh"
module wds_feed_seq (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Feed register writes
    input wire logic clear,
    input wire logic wr,
    input wire logic [7:0] data,
    // Results
    output logic feed_done,
    output logic bad_feed
);
    logic armed;
    wire is_first = (data == `WDS_FEED_FIRST);
    wire is_second = (data == `WDS_FEED_SECOND);
    // Any other value after the opening one, save a repeated 1E, drops the partial sequence
    wire next_armed = clear ? 1'b0 : (wr ? is_first : armed);

    // Writes elsewhere between the two halves leave armed alone
    assign feed_done = wr && armed && is_second;
    assign bad_feed = wr && !is_first && !(armed && is_second);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else begin
            armed <= next_armed;
        end
    end
endmodule

//--- wds_watchdog_top.sv
// Watchdog timer, interval timer and software reset register block
`timescale 1ns/1ps
`include "wds_regs.svh"
// Function
// - Fuse set: counter runs on the block clock, the independent oscillator.
// - Fuse set: software cannot stop the watchdog; no feed means CPU reset.
// - Fuse clear: counter is an interval timer raising an interrupt.
// - Eight timeouts by three-bit select, 16 ms doubling up to about 2 s.
// - Fuse set: control register accepts one write after each reset.
// - Counting never depends on the CPU clock; with the fuse set a stopped CPU is reset.
// - Counter held inactive while power-on, brownout or external reset.
// - Feed is write 1E then E1 to the feed register; restarts interval.
// - Other accesses between the two feed writes are allowed.
// - Wrong feed only sets the bad-feed status bit; expiry stays at its scheduled time.
// - Expiry asserts internal reset for about one microsecond.
// - Reset in power-down starts the oscillator, waits until it is stable.
// - Auxiliary write with bit 3 set fully resets the processor.
// - Auxiliary bit 2 reads zero, ignores writes.
module wds_watchdog_top
    import wds_pkg::*;
#(
    parameter int BASE_CYCLES = `WDS_BASE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire wds_bus_req_type bus,
    output logic [7:0] rdata,
    // Configuration and chip state
    input wire logic watchdog_enable_fuse,
    input wire logic por_reset,
    input wire logic bod_reset,
    input wire logic ext_reset,
    input wire logic power_down,
    input wire logic osc_stable,
    // Chip control
    output logic cpu_reset,
    output logic osc_start,
    output logic pointer_bank_select,
    // Interrupt
    output logic irq
);
    localparam logic [`WDS_PRE_W-1:0] PRE_LIMIT =
        `WDS_PRE_W'(BASE_CYCLES - 1);
    localparam logic [`WDS_PULSE_W-1:0] PULSE_LIMIT =
        `WDS_PULSE_W'(`WDS_RST_PULSE_CYCLES - 1);

    logic [2:0] timeout_select_field;
    logic timer_run;
    logic ctrl_locked;
    logic aux_reserved;
    logic [2:0] status;
    logic [2:0] mask;
    logic [`WDS_PERIOD_W-1:0] period_cnt;
    logic pd_latched;
    wds_rst_state_type rst_state;
    wds_rst_state_type next_rst_state;
    logic base_tick;
    logic pulse_done;
    logic feed_done;
    logic bad_feed;

    // Address decode
    wire wr_aux = bus.wr && (bus.addr == `WDS_AUX_OFFSET);
    wire wr_feed = bus.wr && (bus.addr == `WDS_FEED_OFFSET);
    wire wr_ctrl = bus.wr && (bus.addr == `WDS_CTRL_OFFSET);
    wire wr_status = bus.wr && (bus.addr == `WDS_STATUS_OFFSET);
    wire wr_mask = bus.wr && (bus.addr == `WDS_MASK_OFFSET);

    // Reset sources
    wire other_reset = por_reset | bod_reset | ext_reset;
    wire chip_reset = cpu_reset | other_reset;
    wire rst_idle = (rst_state == WDS_RST_IDLE);

    // Control register write, once per reset while the fuse is set
    wire ctrl_writable = !(watchdog_enable_fuse && ctrl_locked);
    wire ctrl_load = wr_ctrl && ctrl_writable;

    // Run gate: the run bit only matters in interval mode
    wire mode_run = watchdog_enable_fuse | timer_run;
    // Clocked from clk alone, so a halted CPU cannot stall it
    wire counting = mode_run && !other_reset && rst_idle;

    // Prescaler restarts on feed; an idle timer starts afresh
    wire pre_clear = feed_done | !counting;

    // Timeout length in base periods, 2^select
    wire [`WDS_PERIOD_W-1:0] period_last =
        (`WDS_PERIOD_W'(1) << timeout_select_field) -
        `WDS_PERIOD_W'(1);
    // Compare with >= so shrinking the select cannot skip expiry
    wire expire = base_tick && (period_cnt >= period_last);
    wire wd_expire = expire && watchdog_enable_fuse;
    wire int_expire = expire && !watchdog_enable_fuse;
    wire [`WDS_PERIOD_W-1:0] period_inc = period_cnt + `WDS_PERIOD_W'(1);
    wire [`WDS_PERIOD_W-1:0] next_period =
        pre_clear ? '0 :
        expire ? '0 :
        base_tick ? period_inc : period_cnt;

    // Reset requests
    wire sw_reset = wr_aux && bus.wdata[`WDS_AUX_SOFTWARE_RESET_BIT_BIT];
    wire reset_trigger = wd_expire | sw_reset;

    // Interrupt status: set wins over a clearing write
    wire [2:0] st_set = {wd_expire, bad_feed, int_expire};
    wire [2:0] st_clr = wr_status ? bus.wdata[2:0] : 3'h0;
    wire [2:0] next_status = (status & ~st_clr) | st_set;
    wire [2:0] next_mask = chip_reset ? `WDS_MASK_RESET :
                           wr_mask ? bus.wdata[2:0] : mask;

    // Read selection
    wire [7:0] aux_rd = {4'h0, 1'b0, 1'b0, aux_reserved,
                         pointer_bank_select};
    wire [7:0] ctrl_rd = {1'b0, watchdog_enable_fuse, ctrl_locked,
                          timer_run, 1'b0, timeout_select_field};
    wire [7:0] status_rd = {5'h00, status};
    wire [7:0] mask_rd = {5'h00, mask};
    wire [7:0] rd_mux =
        (bus.addr == `WDS_AUX_OFFSET) ? aux_rd :
        (bus.addr == `WDS_CTRL_OFFSET) ? ctrl_rd :
        (bus.addr == `WDS_STATUS_OFFSET) ? status_rd :
        (bus.addr == `WDS_MASK_OFFSET) ? mask_rd :
        (bus.addr == `WDS_COUNT_OFFSET) ? period_cnt : 8'h00;

    // Base period prescaler
    wds_counter #(.W(`WDS_PRE_W)) u_prescale (
        .clk(clk),
        .rst_n(rst_n),
        .clear(pre_clear),
        .run(counting),
        .limit(PRE_LIMIT),
        .done(base_tick)
    );

    // Internal reset pulse width
    wds_counter #(.W(`WDS_PULSE_W)) u_pulse (
        .clk(clk),
        .rst_n(rst_n),
        .clear(rst_state != WDS_RST_PULSE),
        .run(rst_state == WDS_RST_PULSE),
        .limit(PULSE_LIMIT),
        .done(pulse_done)
    );

    // Feed sequence; a chip reset drops a half-done feed
    wds_feed_seq u_feed (
        .clk(clk),
        .rst_n(rst_n),
        .clear(chip_reset),
        .wr(wr_feed),
        .data(bus.wdata),
        .feed_done(feed_done),
        .bad_feed(bad_feed)
    );

    // Reset sequencer
    always_comb begin
        next_rst_state = rst_state;
        unique case (rst_state)
            WDS_RST_IDLE: begin
                if (reset_trigger) begin
                    next_rst_state = WDS_RST_PULSE;
                end
            end
            WDS_RST_PULSE: begin
                if (pulse_done) begin
                    // Power-down needs the main oscillator back first
                    next_rst_state = pd_latched ? WDS_RST_OSC_WAIT :
                                     WDS_RST_IDLE;
                end
            end
            WDS_RST_OSC_WAIT: begin
                if (osc_stable) begin
                    next_rst_state = WDS_RST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_state <= WDS_RST_IDLE;
            cpu_reset <= 1'b0;
            osc_start <= 1'b0;
        end else begin
            rst_state <= next_rst_state;
            cpu_reset <= (next_rst_state != WDS_RST_IDLE);
            osc_start <= (next_rst_state == WDS_RST_OSC_WAIT);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pd_latched <= 1'b0;
        end else if (rst_idle && reset_trigger) begin
            pd_latched <= power_down;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            period_cnt <= '0;
        end else begin
            period_cnt <= next_period;
        end
    end

    // Control register
    always_ff @(posedge clk) begin
        if (!rst_n || chip_reset) begin
            timeout_select_field <= `WDS_CTRL_SEL_RESET;
            timer_run <= 1'b0;
            ctrl_locked <= 1'b0;
        end else if (ctrl_load) begin
            timeout_select_field <= bus.wdata[2:0];
            timer_run <= bus.wdata[`WDS_CTRL_RUN_BIT];
            ctrl_locked <= watchdog_enable_fuse;
        end
    end

    // Auxiliary register; bit 2 has no storage at all
    always_ff @(posedge clk) begin
        if (!rst_n || chip_reset) begin
            pointer_bank_select <= 1'(`WDS_AUX_RESET >> `WDS_AUX_PBS_BIT);
            aux_reserved <= 1'b0;
        end else if (wr_aux) begin
            pointer_bank_select <= bus.wdata[`WDS_AUX_PBS_BIT];
            aux_reserved <= bus.wdata[`WDS_AUX_RSVD_BIT];
        end
    end

    // Status survives chip resets so software can see why it restarted
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status <= `WDS_ST_RESET;
            mask <= `WDS_MASK_RESET;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            mask <= next_mask;
            irq <= |(next_status & next_mask);
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else begin
            rdata <= bus.rd ? rd_mux : 8'h00;
        end
    end
endmodule

//--- wds_watchdog_top_asserts.sv
// Concurrent checks on the ports of the watchdog block
`timescale 1ns/1ps
`include "wds_regs.svh"
module wds_watchdog_top_asserts
    import wds_pkg::*;
#(
    parameter int BASE_CYCLES = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire wds_bus_req_type bus,
    input wire logic [7:0] rdata,
    // Configuration and chip state
    input wire logic watchdog_enable_fuse,
    input wire logic por_reset,
    input wire logic bod_reset,
    input wire logic ext_reset,
    input wire logic power_down,
    input wire logic osc_stable,
    // Chip control and interrupt
    input wire logic cpu_reset,
    input wire logic osc_start,
    input wire logic pointer_bank_select,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] hi_cnt;
    wire aux_wr = bus.wr && bus.addr == `WDS_AUX_OFFSET;
    wire sw_rst = aux_wr && bus.wdata[3];
    wire chip_src = por_reset || bod_reset || ext_reset;
    // Saturates so a long oscillator wait cannot wrap it
    always_ff @(posedge clk) begin
        if (!rst_n || !cpu_reset)
            hi_cnt <= 8'h00;
        else if (hi_cnt != 8'hFF)
            hi_cnt <= hi_cnt + 8'h01;
    end
    aux_read_a: assert property (
        $past(bus.rd) && $past(bus.addr) == `WDS_AUX_OFFSET |->
        rdata[7:2] == 6'h00 && rdata[0] == $past(pointer_bank_select))
        else $error("aux read shows a fixed bit set");
    fuse_read_a: assert property (
        $past(bus.rd) && $past(bus.addr) == `WDS_CTRL_OFFSET |->
        rdata[6] == $past(watchdog_enable_fuse))
        else $error("control read does not show the fuse");
    sw_reset_a: assert property (
        sw_rst |=> cpu_reset [*8])
        else $error("software reset did not start");
    pbs_write_a: assert property (
        aux_wr && !bus.wdata[3] && !cpu_reset && !chip_src |=>
        pointer_bank_select == $past(bus.wdata[0]))
        else $error("pointer bank select not written");
    pulse_len_a: assert property (
        $fell(cpu_reset) && !$past(osc_start) |-> hi_cnt == 8'h28)
        else $error("reset pulse length wrong");
    osc_hold_a: assert property (
        osc_start && !osc_stable |=> osc_start && cpu_reset)
        else $error("reset dropped before oscillator stable");
    osc_drop_a: assert property (
        osc_start && osc_stable |=> !osc_start && !cpu_reset)
        else $error("reset held after oscillator stable");
    no_reset_int_a: assert property (
        $rose(cpu_reset) |->
        $past(sw_rst) || $past(watchdog_enable_fuse))
        else $error("interval timer reset the chip");
    hold_src_a: assert property (
        $rose(cpu_reset) |-> $past(sw_rst) || !$past(chip_src))
        else $error("watchdog ran during chip reset");
endmodule
bind wds_watchdog_top wds_watchdog_top_asserts #(
    .BASE_CYCLES(BASE_CYCLES)
) u_chk (
    .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .watchdog_enable_fuse(watchdog_enable_fuse), .por_reset(por_reset),
    .bod_reset(bod_reset), .ext_reset(ext_reset),
    .power_down(power_down), .osc_stable(osc_stable),
    .cpu_reset(cpu_reset), .osc_start(osc_start),
    .pointer_bank_select(pointer_bank_select), .irq(irq)
);

//--- wds_watchdog_top_tb_top.sv
// Self-checking bench for the watchdog and soft reset block
`timescale 1ns/1ps
module wds_watchdog_top_tb_top import wds_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wds_bus_req_type bus = '0;
    logic fuse = 1'b0, por = 1'b0, bod = 1'b0, ext = 1'b0;
    logic pdown = 1'b0, ostab = 1'b0;
    logic [7:0] rdata;
    logic cpu_reset, osc_start, pbs, irq;
    int fails = 0, n_checks = 0, mdl [256], n1, n2, n3;
    bit armed, locked;
    logic [31:0] seed = 32'h9992F044;
    logic [7:0] regs [7] = '{8'hA2, 8'hA6, 8'hA7, 8'hA8, 8'hA9, 8'hAA,
                             8'hB0};
    always #12.5 clk = ~clk;
    // Short base period keeps the 2^sel ladder within a quick run
    wds_watchdog_top #(.BASE_CYCLES(8)) u_dut (
        .clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .watchdog_enable_fuse(fuse), .por_reset(por), .bod_reset(bod),
        .ext_reset(ext), .power_down(pdown), .osc_stable(ostab),
        .cpu_reset(cpu_reset), .osc_start(osc_start),
        .pointer_bank_select(pbs), .irq(irq)
    );
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task give_verdict();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task xfer(input logic [7:0] a, d, input logic w, r);
        @(posedge clk);
        bus <= '{a, d, w, r};
        #1;
    endtask
    task cyc(input int n);
        repeat (n) xfer(8'h00, 8'h00, 1'b0, 1'b0);
    endtask
    task chip();
        mdl[8'hA2] = 0;
        mdl[8'hA7] = 7;
        mdl[8'hA9] = 0;
        armed = 0;
        locked = 0;
    endtask
    task wr(input logic [7:0] a, d);
        xfer(a, d, 1'b1, 1'b0);
        case (a)
            8'hA2: if (d[3]) chip(); else mdl[a] = d & 3;
            8'hA6: begin
                if (d != 8'h1E && !(armed && d == 8'hE1))
                    mdl[8'hA8] |= 2;
                armed = d == 8'h1E;
            end
            8'hA7: if (!(fuse && locked)) begin
                mdl[a] = (d & 8'h17) | (fuse << 5);
                locked = fuse;
            end
            8'hA8: mdl[a] &= ~d;
            8'hA9: mdl[a] = d & 7;
            default: ;
        endcase
    endtask
    task rd(input logic [7:0] a);
        logic [7:0] e;
        e = 8'(mdl[a]);
        if (a == 8'hA7)
            e[6] = fuse;
        xfer(a, 8'h00, 1'b0, 1'b1);
        cyc(1);
        chk(rdata, e);
    endtask
    // A hang here ends the run rather than stalling it
    task automatic wait_hi(ref logic s, output int n);
        n = 0;
        while (s !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 3000) begin
                fails++;
                give_verdict();
            end
        end
    endtask
    task pulse();
        int k;
        k = 0;
        while (cpu_reset === 1'b1 && k < 100) begin
            k++;
            cyc(1);
        end
        chk(8'(k), 8'h28);
    endtask
    task run(input bit bad, input logic [7:0] sel, output int n);
        logic [7:0] fa;
        fa = bad ? 8'hA6 : 8'hB0;
        wr(8'hA6, 8'h1E);
        rd(8'hA7);
        wr(8'hA6, 8'hE1);
        wr(8'hA7, sel);
        wr(8'hA7, 8'h00);
        rd(8'hA7);
        repeat (6) begin
            cyc(6);
            wr(8'hA6, 8'h1E);
            wr(8'hA6, 8'hE1);
            chk({7'h00, cpu_reset}, 8'h00);
        end
        wr(fa, 8'h1E);
        wr(fa, 8'h55);
        wr(fa, 8'hE1);
        wait_hi(cpu_reset, n);
        mdl[8'hA8] |= 4;
        pulse();
        chip();
        rd(8'hA8);
        wr(8'hA8, 8'h07);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        chip();
        // Count register reads zero while the timer is idle
        for (int i = 0; i < 7; i++)
            rd(regs[i]);
        repeat (4) begin
            seed = lfsr(seed);
            wr(8'hA2, seed[7:0] & 8'hF7);
            rd(8'hA2);
        end
        $display("test registers done");
        wr(8'hA9, 8'h01);
        wr(8'hA7, 8'h10);
        wait_hi(irq, n1);
        mdl[8'hA8] |= 1;
        wr(8'hA7, 8'h00);
        rd(8'hA8);
        chk({7'h00, cpu_reset}, 8'h00);
        wr(8'hA8, 8'h01);
        rd(8'hA8);
        chk({7'h00, irq}, 8'h00);
        wr(8'hA9, 8'h00);
        wr(8'hA7, 8'h10);
        cyc(40);
        chk({7'h00, irq}, 8'h00);
        wr(8'hA7, 8'h00);
        mdl[8'hA8] |= 1;
        rd(8'hA8);
        wr(8'hA8, 8'h01);
        $display("test interval done");
        wr(8'hA2, 8'h01);
        wr(8'hA2, 8'h09);
        cyc(1);
        pulse();
        rd(8'hA2);
        $display("test soft reset done");
        fuse <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            {ext, bod, por} <= 3'b001 << i;
            cyc(1200);
            chk({7'h00, cpu_reset}, 8'h00);
        end
        {ext, bod, por} <= 3'b000;
        chip();
        rd(8'hA8);
        run(0, 8'h01, n1);
        run(1, 8'h01, n2);
        run(0, 8'h02, n3);
        chk(8'(n2), 8'(n1));
        chk(8'(n3 - n1), 8'h10);
        $display("test watchdog done");
        pdown <= 1'b1;
        wr(8'hA7, 8'h00);
        wait_hi(cpu_reset, n1);
        mdl[8'hA8] |= 4;
        cyc(60);
        chk({6'h00, osc_start, cpu_reset}, 8'h03);
        ostab <= 1'b1;
        cyc(3);
        chk({6'h00, osc_start, cpu_reset}, 8'h00);
        pdown <= 1'b0;
        chip();
        rd(8'hA8);
        $display("test power down done");
        give_verdict();
    end
endmodule
